// *** rtl/nvm_port_pkg.sv ***
// Purpose: shared constants and types for the parallel nvm programming port
// Assumes: one 100 MHz clock on both ends, synchronous active-high reset
// Notes:   pin vector layout is used only by the device end's pin sampler
package nvm_port_pkg;
	// action select codes {hi, lo}
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;
	// command bytes
	localparam logic [7:0] CMD_NOOP     = 8'h00;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE    = 8'h11;
	localparam logic [7:0] CMD_RD_SIG   = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE    = 8'h03;
	// memory geometry
	localparam int FLASH_AW   = 12;
	localparam int FLASH_WORD = 5;
	localparam int EE_AW      = 6;
	localparam int EE_WORD    = 2;
	localparam int SIG_COUNT  = 3;
	// reset values, erased state
	localparam logic [7:0]  FUSE_LO_RST  = 8'hFF;
	localparam logic [7:0]  FUSE_HI_RST  = 8'hFF;
	localparam logic [7:0]  FUSE_EXT_RST = 8'hFF;
	localparam logic [7:0]  LOCK_RST     = 8'hFF;
	localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
	localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
	// lock bit positions
	localparam int LOCK_ONE = 0;
	localparam int LOCK_TWO = 1;
	// timing
	localparam int CLK_NS        = 10;
	localparam int PULSE_MIN_NS  = 250;
	localparam int PULSE_CYCLES  = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUSY_CYCLES   = 16;
	// pin vector positions
	localparam int PIN_W    = 16;
	localparam int PIN_XA0  = 8;
	localparam int PIN_XA1  = 9;
	localparam int PIN_BS1  = 10;
	localparam int PIN_BS2  = 11;
	localparam int PIN_LOAD = 12;
	localparam int PIN_PAGE = 13;
	localparam int PIN_WRN  = 14;
	localparam int PIN_OEN  = 15;
	// programmer request kinds
	typedef enum logic [2:0] {
		REQ_CMD, REQ_ADDR, REQ_DATA, REQ_LATCH, REQ_WRITE, REQ_READ
	} req_kind_t;
endpackage

// *** rtl/nvm_prog_if.sv ***
// Purpose: pin bundle between the programmer and the nvm device
// Assumes: data bus has a weak pull-up when nobody drives it
// Notes:   bus level is resolved here from both output enables
`timescale 1ns/1ps
interface nvm_prog_if;
	logic       actionSelectHi;
	logic       actionSelectLo;
	logic       byteSelectFirst;
	logic       byteSelectSecond;
	logic       loadPulseInput;
	logic       pageLatchStrobe;
	logic       writeStrobeN;
	logic       outputEnableN;
	logic       readyBusyOut;
	logic [7:0] hostData;
	logic       hostDataOe;
	logic [7:0] devData;
	logic       devDataOe;
	logic [7:0] dataBus;

	// device wins a contention so a wrong host shows up as bad data
	assign dataBus = devDataOe ? devData :
		(hostDataOe ? hostData : nvm_port_pkg::ERASED_BYTE);

	modport device (
		input  actionSelectHi, actionSelectLo, byteSelectFirst,
		input  byteSelectSecond, loadPulseInput, pageLatchStrobe,
		input  writeStrobeN, outputEnableN, dataBus,
		output readyBusyOut, devData, devDataOe
	);
	modport host (
		output actionSelectHi, actionSelectLo, byteSelectFirst,
		output byteSelectSecond, loadPulseInput, pageLatchStrobe,
		output writeStrobeN, outputEnableN, hostData, hostDataOe,
		input  readyBusyOut, dataBus
	);
endinterface // nvm_prog_if

// *** rtl/nvm_device_port.sv ***
// Purpose: device end of the parallel programming port with its memories
// Assumes: pins are asynchronous to clk; pulses last several clocks
// Notes:   arrays hold no reset value; erase before first page program
`timescale 1ns/1ps
module nvm_device_port #(
	parameter int         BUSY_CNT = nvm_port_pkg::BUSY_CYCLES,
	parameter logic [7:0] SIG_B0   = 8'h5A, // arbitrary identity value
	parameter logic [7:0] SIG_B1   = 8'hA5, // arbitrary identity value
	parameter logic [7:0] SIG_B2   = 8'h3C, // arbitrary identity value
	parameter logic [7:0] CALIB    = 8'h80  // arbitrary calibration value
) (
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      ce,
	nvm_prog_if.device     pins
);
	localparam int FW = 1 << nvm_port_pkg::FLASH_WORD;
	localparam int EW = 1 << nvm_port_pkg::EE_WORD;

	typedef struct packed {
		logic [nvm_port_pkg::PIN_W-1:0] s1;
		logic [nvm_port_pkg::PIN_W-1:0] s2;
		logic [nvm_port_pkg::PIN_W-1:0] s3;
		logic [7:0]  cmd;
		logic [7:0]  addrLo;
		logic [7:0]  addrHi;
		logic [7:0]  dataLo;
		logic [7:0]  dataHi;
		logic [7:0]  fuseLo;
		logic [7:0]  fuseHi;
		logic [7:0]  fuseExt;
		logic [7:0]  lockBits;
		logic [7:0]  rdData;
		logic        dataOe;
		logic        busy;
		logic [15:0] busyCnt;
	} dev_state_t;

	localparam dev_state_t STATE_RST = '{
		s1: '1, s2: '1, s3: '1,
		cmd: nvm_port_pkg::CMD_NOOP, addrLo: 8'h00, addrHi: 8'h00,
		dataLo: 8'h00, dataHi: 8'h00,
		fuseLo: nvm_port_pkg::FUSE_LO_RST, fuseHi: nvm_port_pkg::FUSE_HI_RST,
		fuseExt: nvm_port_pkg::FUSE_EXT_RST, lockBits: nvm_port_pkg::LOCK_RST,
		rdData: 8'h00, dataOe: 1'b0, busy: 1'b0, busyCnt: 16'h0000
	};

	dev_state_t r;
	dev_state_t n;

	logic [15:0] flashMem [0:(1<<nvm_port_pkg::FLASH_AW)-1];
	logic [7:0]  eeMem    [0:(1<<nvm_port_pkg::EE_AW)-1];
	logic [15:0] flashBuf [0:FW-1];
	logic [7:0]  eeBuf    [0:EW-1];
	logic [FW-1:0] flashMask;
	logic [EW-1:0] eeMask;

	logic loadEdge;
	logic latchEdge;
	logic writeEdge;
	logic progFlash;
	logic progEe;
	logic doErase;
	logic clearBuf;
	logic [nvm_port_pkg::FLASH_AW-1:0] flashAddr;
	logic [nvm_port_pkg::EE_AW-1:0]    eeAddr;
	logic [15:0]                       addrFull;

	// word address from both held bytes; the top four bits go unused
	assign addrFull  = {r.addrHi, r.addrLo};
	assign flashAddr = addrFull[nvm_port_pkg::FLASH_AW-1:0];
	assign eeAddr    = addrFull[nvm_port_pkg::EE_AW-1:0];

	// pin edges seen only on the second and third stages
	assign loadEdge  = r.s2[nvm_port_pkg::PIN_LOAD] &
		~r.s3[nvm_port_pkg::PIN_LOAD] & ~r.busy;
	assign latchEdge = r.s2[nvm_port_pkg::PIN_PAGE] &
		~r.s3[nvm_port_pkg::PIN_PAGE] & ~r.busy;
	assign writeEdge = ~r.s2[nvm_port_pkg::PIN_WRN] &
		r.s3[nvm_port_pkg::PIN_WRN] & ~r.busy;

	// next-state logic for the whole control struct
	always_comb begin
		logic [1:0] act;
		logic [1:0] sel;
		logic [7:0] bus;
		logic       start;
		act = {r.s2[nvm_port_pkg::PIN_XA1], r.s2[nvm_port_pkg::PIN_XA0]};
		sel = {r.s2[nvm_port_pkg::PIN_BS2], r.s2[nvm_port_pkg::PIN_BS1]};
		bus = r.s2[7:0];
		start = 1'b0;
		n = r;
		progFlash = 1'b0;
		progEe = 1'b0;
		doErase = 1'b0;
		clearBuf = 1'b0;
		n.s1 = {pins.outputEnableN, pins.writeStrobeN, pins.pageLatchStrobe,
			pins.loadPulseInput, pins.byteSelectSecond, pins.byteSelectFirst,
			pins.actionSelectHi, pins.actionSelectLo, pins.dataBus};
		n.s2 = r.s1;
		n.s3 = r.s2;
		// loads keep their value until overwritten
		if (loadEdge) begin
			case (act)
				nvm_port_pkg::ACT_ADDR: begin
					if (sel[0]) begin
						n.addrHi = bus;
					end else begin
						n.addrLo = bus;
					end
				end
				nvm_port_pkg::ACT_DATA: begin
					if (sel[0]) begin
						n.dataHi = bus;
					end else begin
						n.dataLo = bus;
					end
				end
				nvm_port_pkg::ACT_CMD: begin
					n.cmd = bus;
					clearBuf = (bus == nvm_port_pkg::CMD_NOOP);
				end
				default: ; // idle action leaves everything
			endcase
		end
		// write pulse acts on the held command
		if (writeEdge) begin
			case (r.cmd)
				nvm_port_pkg::CMD_WR_FLASH: begin
					progFlash = 1'b1;
					start = 1'b1;
				end
				nvm_port_pkg::CMD_WR_EE: begin
					progEe = 1'b1;
					start = 1'b1;
				end
				nvm_port_pkg::CMD_WR_FUSE: begin
					start = 1'b1;
					case (sel)
						2'b00: n.fuseLo = r.dataLo;
						2'b01: n.fuseHi = r.dataLo;
						2'b10: n.fuseExt = r.dataLo;
						default: ;
					endcase
				end
				nvm_port_pkg::CMD_WR_LOCK: begin
					// once both bits programmed, writes are silently dropped
					if (r.lockBits[nvm_port_pkg::LOCK_ONE] |
						r.lockBits[nvm_port_pkg::LOCK_TWO]) begin
						n.lockBits = r.lockBits & r.dataLo;
						start = 1'b1;
					end
				end
				nvm_port_pkg::CMD_ERASE: begin
					doErase = 1'b1;
					n.lockBits = nvm_port_pkg::LOCK_RST;
					start = 1'b1;
				end
				default: ;
			endcase
		end
		// busy timer drives ready low for BUSY_CNT cycles
		if (start) begin
			n.busy = 1'b1;
			n.busyCnt = 16'(BUSY_CNT - 1);
		end else if (r.busy) begin
			if (r.busyCnt == 16'h0000) begin
				n.busy = 1'b0;
			end else begin
				n.busyCnt = r.busyCnt - 16'h0001;
			end
		end
		// read data mux by held command and selects
		n.rdData = nvm_port_pkg::ERASED_BYTE;
		case (r.cmd)
			nvm_port_pkg::CMD_RD_FLASH: n.rdData = sel[0] ?
				flashMem[flashAddr][15:8] : flashMem[flashAddr][7:0];
			nvm_port_pkg::CMD_RD_EE: begin
				if (!sel[0]) begin
					n.rdData = eeMem[eeAddr];
				end
			end
			nvm_port_pkg::CMD_RD_FUSE: begin
				case (sel)
					2'b00: n.rdData = r.fuseLo;
					2'b11: n.rdData = r.fuseHi;
					2'b10: n.rdData = r.fuseExt;
					default: n.rdData = r.lockBits;
				endcase
			end
			nvm_port_pkg::CMD_RD_SIG: begin
				if (sel[0]) begin
					if (r.addrLo == 8'h00) begin
						n.rdData = CALIB;
					end
				end else begin
					case (r.addrLo)
						8'h00: n.rdData = SIG_B0;
						8'h01: n.rdData = SIG_B1;
						8'h02: n.rdData = SIG_B2;
						default: ;
					endcase
				end
			end
			default: ;
		endcase
		n.dataOe = ~r.s2[nvm_port_pkg::PIN_OEN];
	end

	// control state register
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= STATE_RST;
		end else if (ce) begin
			r <= n;
		end
	end

	// page buffers and arrays; masks keep unlatched words untouched
	always_ff @(posedge clk) begin
		if (rst) begin
			flashMask <= '0;
			eeMask <= '0;
		end else if (ce) begin
			// page index from upper address bits
			if (progFlash) begin
				for (int i = 0; i < FW; i++) begin
					if (flashMask[i]) begin
						flashMem[{flashAddr[nvm_port_pkg::FLASH_AW-1:
							nvm_port_pkg::FLASH_WORD],
							i[nvm_port_pkg::FLASH_WORD-1:0]}] <= flashBuf[i];
					end
				end
				flashMask <= '0;
			end
			if (progEe) begin
				for (int i = 0; i < EW; i++) begin
					if (eeMask[i]) begin
						eeMem[{eeAddr[nvm_port_pkg::EE_AW-1:
							nvm_port_pkg::EE_WORD],
							i[nvm_port_pkg::EE_WORD-1:0]}] <= eeBuf[i];
					end
				end
				eeMask <= '0;
			end
			if (doErase) begin
				for (int i = 0; i < (1 << nvm_port_pkg::FLASH_AW); i++) begin
					flashMem[i] <= nvm_port_pkg::ERASED_WORD;
				end
				for (int i = 0; i < (1 << nvm_port_pkg::EE_AW); i++) begin
					eeMem[i] <= nvm_port_pkg::ERASED_BYTE;
				end
			end
			if (clearBuf) begin
				flashMask <= '0;
				eeMask <= '0;
			end
			if (latchEdge) begin // last, so a latch wins over a clear
				if (r.cmd == nvm_port_pkg::CMD_WR_EE) begin
					eeBuf[eeAddr[nvm_port_pkg::EE_WORD-1:0]] <= r.dataLo;
					eeMask[eeAddr[nvm_port_pkg::EE_WORD-1:0]] <= 1'b1;
				end else begin
					flashBuf[flashAddr[nvm_port_pkg::FLASH_WORD-1:0]] <=
						{r.dataHi, r.dataLo};
					flashMask[flashAddr[nvm_port_pkg::FLASH_WORD-1:0]] <=
						1'b1;
				end
			end
		end
	end

	assign pins.readyBusyOut = ~r.busy;
	assign pins.devData      = r.rdData;
	assign pins.devDataOe    = r.dataOe;
endmodule // nvm_device_port

// *** rtl/nvm_programmer.sv ***
// Purpose: programmer end; turns one request into one timed pin sequence
// Assumes: caller orders requests as the page sequences demand
// Notes:   setup, strobe and hold each last PULSE cycles, the documented least pulse
`timescale 1ns/1ps
module nvm_programmer #(
	parameter int PULSE = nvm_port_pkg::PULSE_CYCLES
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   reqValid,
	output logic                        reqReady,
	input  nvm_port_pkg::req_kind_t     reqKind,
	input  wire logic [7:0]             reqByte,
	input  wire logic                   reqBs1,
	input  wire logic                   reqBs2,
	output logic                        rspValid,
	output logic [7:0]                  rspData,
	output logic                        devReady,
	nvm_prog_if.host                    pins
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD,
		ST_WAIT} host_st_t;

	typedef struct packed {
		host_st_t                st;
		logic [7:0]              cnt;
		nvm_port_pkg::req_kind_t kind;
		logic [1:0]              act;
		logic                    bs1;
		logic                    bs2;
		logic                    load;
		logic                    page;
		logic                    wrN;
		logic                    oeN;
		logic [7:0]              dOut;
		logic                    dOe;
		logic [7:0]              rsp;
		logic                    rspV;
		logic [1:0]              rdySync;
		logic [7:0]              din1;
		logic [7:0]              din2;
	} host_state_t;

	localparam host_state_t HOST_RST = '{
		st: ST_IDLE, cnt: 8'h00, kind: nvm_port_pkg::REQ_CMD,
		act: nvm_port_pkg::ACT_IDLE, bs1: 1'b0, bs2: 1'b0, load: 1'b0,
		page: 1'b0, wrN: 1'b1, oeN: 1'b1, dOut: 8'h00, dOe: 1'b0,
		rsp: 8'h00, rspV: 1'b0, rdySync: 2'b00, din1: 8'h00, din2: 8'h00
	};
	localparam logic [7:0] LAST = 8'(PULSE - 1);

	host_state_t r;
	host_state_t n;

	// accept only when idle and the device shows ready
	assign reqReady = (r.st == ST_IDLE) & r.rdySync[1];

	// one phase per PULSE cycles: setup, strobe, hold, then ready wait
	always_comb begin
		n = r;
		n.rspV = 1'b0;
		n.rdySync = {r.rdySync[0], pins.readyBusyOut};
		n.din1 = pins.dataBus;
		n.din2 = r.din1;
		case (r.st)
			ST_IDLE: begin
				if (reqValid & reqReady) begin
					n.st = ST_SETUP;
					n.cnt = 8'h00;
					n.kind = reqKind;
					n.bs1 = reqBs1;
					n.bs2 = reqBs2;
					n.dOut = reqByte;
					n.act = nvm_port_pkg::ACT_IDLE;
					n.dOe = 1'b0;
					case (reqKind)
						nvm_port_pkg::REQ_CMD: begin
							n.act = nvm_port_pkg::ACT_CMD;
							n.dOe = 1'b1;
						end
						nvm_port_pkg::REQ_ADDR: begin
							n.act = nvm_port_pkg::ACT_ADDR;
							n.dOe = 1'b1;
						end
						nvm_port_pkg::REQ_DATA: begin
							n.act = nvm_port_pkg::ACT_DATA;
							n.dOe = 1'b1;
						end
						nvm_port_pkg::REQ_READ: n.oeN = 1'b0;
						default: ;
					endcase
				end
			end
			ST_SETUP: begin
				n.cnt = r.cnt + 8'h01;
				if (r.cnt == LAST) begin
					n.st = ST_STROBE;
					n.cnt = 8'h00;
					case (r.kind)
						nvm_port_pkg::REQ_LATCH: n.page = 1'b1;
						nvm_port_pkg::REQ_WRITE: n.wrN = 1'b0;
						nvm_port_pkg::REQ_READ: ;
						default: n.load = 1'b1;
					endcase
				end
			end
			ST_STROBE: begin
				n.cnt = r.cnt + 8'h01;
				if (r.cnt == LAST) begin
					n.st = ST_HOLD;
					n.cnt = 8'h00;
					n.load = 1'b0;
					n.page = 1'b0;
					n.wrN = 1'b1;
					if (r.kind == nvm_port_pkg::REQ_READ) begin
						n.rsp = r.din2; // bus settled long before this
						n.rspV = 1'b1;
						n.oeN = 1'b1;
					end
				end
			end
			ST_HOLD: begin
				n.cnt = r.cnt + 8'h01;
				if (r.cnt == LAST) begin
					n.dOe = 1'b0;
					n.act = nvm_port_pkg::ACT_IDLE;
					n.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// hold phase outlasts the device's ready latency
				if (r.rdySync[1]) begin
					n.st = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase
	end

	// host state register
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= HOST_RST;
		end else if (ce) begin
			r <= n;
		end
	end

	assign pins.actionSelectHi   = r.act[1];
	assign pins.actionSelectLo   = r.act[0];
	assign pins.byteSelectFirst  = r.bs1;
	assign pins.byteSelectSecond = r.bs2;
	assign pins.loadPulseInput   = r.load;
	assign pins.pageLatchStrobe  = r.page;
	assign pins.writeStrobeN     = r.wrN;
	assign pins.outputEnableN    = r.oeN;
	assign pins.hostData         = r.dOut;
	assign pins.hostDataOe       = r.dOe;
	assign rspValid              = r.rspV;
	assign rspData               = r.rsp;
	assign devReady              = r.rdySync[1];
endmodule // nvm_programmer

// *** verification/nvm_port_props.sv ***
// Purpose: pin-level checks on the programmer to device link
// Assumes: one clock; the bench runs busy length 2 and pulse length 6
// Notes:   busy length is a plain count, keep it in step with the bench
`timescale 1ns/1ps
module nvm_port_props (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       actionSelectHi,
	input wire logic       actionSelectLo,
	input wire logic       loadPulseInput,
	input wire logic       pageLatchStrobe,
	input wire logic       writeStrobeN,
	input wire logic       outputEnableN,
	input wire logic       readyBusyOut,
	input wire logic [7:0] hostData,
	input wire logic       hostDataOe,
	input wire logic       devDataOe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// busy may only start from a write strobe seen through the sync chain
	property p_busy_cause;
		$fell(readyBusyOut) |-> !$past(writeStrobeN) || !$past(writeStrobeN, 2);
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy without write strobe");

	// busy lasts the configured length, then ready returns
	property p_busy_len;
		$fell(readyBusyOut) |-> !readyBusyOut[*2] ##1 readyBusyOut;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong");

	// a long quiet write strobe means the device must be ready again
	property p_ready_after;
		writeStrobeN[*8] |-> readyBusyOut;
	endproperty
	a_ready_after: assert property (p_ready_after)
		else $error("ready did not return");

	// device drive starts only while output enable is low
	property p_oe_rise;
		$rose(devDataOe) |-> !outputEnableN;
	endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("bus driven without output enable");

	// output enable low must turn the device driver on within the sync delay
	property p_oe_follow;
		$fell(outputEnableN) |-> ##[2:5] devDataOe;
	endproperty
	a_oe_follow: assert property (p_oe_follow)
		else $error("bus not driven after output enable");

	// a settled high output enable keeps the device off the bus
	property p_oe_off;
		outputEnableN[*5] |-> !devDataOe;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("bus driven with output enable high");

	// both ends driving at once would corrupt the byte
	property p_no_clash;
		!(devDataOe && hostDataOe);
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("bus contention");

	// byte and action code must be settled when the load pulse rises
	property p_load_stable;
		$rose(loadPulseInput) |-> hostDataOe && $stable(hostData) &&
			$stable(actionSelectHi) && $stable(actionSelectLo);
	endproperty
	a_load_stable: assert property (p_load_stable)
		else $error("load pulse with moving data");

	// no new load or latch while the device reports busy
	property p_wait_busy;
		!readyBusyOut |-> !$rose(loadPulseInput) && !$rose(pageLatchStrobe);
	endproperty
	a_wait_busy: assert property (p_wait_busy)
		else $error("strobe while busy");

	// the page latch pulse stands alone among the strobes
	property p_latch_alone;
		$rose(pageLatchStrobe) |-> !loadPulseInput && writeStrobeN &&
			outputEnableN;
	endproperty
	a_latch_alone: assert property (p_latch_alone)
		else $error("latch overlaps another strobe");
endmodule // nvm_port_props

// *** verification/parallel_nvm_program_port_tb.sv ***
// Purpose: drives the programmer user side, checks read-back bytes
// Assumes: short pulse and busy counts keep the run brief
// Notes:   expected bytes are queued at request time, compared on answer
`timescale 1ns/1ps
module parallel_nvm_program_port_tb;
	localparam int         PULSE = 6;
	localparam int         BUSY  = 2;
	// identity bytes are arbitrary, the last entry is the blank answer
	localparam logic [7:0] SIGS [4] = '{8'h4B, 8'hB4, 8'h69, 8'hFF};
	localparam logic [7:0] CAL      = 8'h96; // arbitrary
	localparam logic [7:0] LK_IN [3] = '{8'hFE, 8'hFD, 8'h00};
	localparam logic [7:0] LK_EXP [3] = '{8'hFE, 8'hFC, 8'hFC};
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    reqValid = 1'b0;
	nvm_port_pkg::req_kind_t reqKind = nvm_port_pkg::REQ_CMD;
	logic [7:0]              reqByte = 8'h00;
	logic                    reqBs1 = 1'b0;
	logic                    reqBs2 = 1'b0;
	logic                    reqReady;
	logic                    rspValid;
	logic [7:0]              rspData;
	logic                    devReady;
	logic [7:0]              expQ[$];
	logic [15:0]             w [2];
	logic [7:0]              e [2];
	logic [7:0]              f [3];
	int                      failCount = 0;
	int                      checkCount = 0;
	int                      cycles = 0;
	int                      seed = 40007;
	int                      i;

	nvm_prog_if bus ();
	nvm_programmer #(.PULSE(PULSE)) nvm_programmer_i (
		.clk(clk), .rst(rst), .ce(1'b1), .reqValid(reqValid),
		.reqReady(reqReady), .reqKind(reqKind), .reqByte(reqByte),
		.reqBs1(reqBs1), .reqBs2(reqBs2), .rspValid(rspValid),
		.rspData(rspData), .devReady(devReady), .pins(bus));
	nvm_device_port #(.BUSY_CNT(BUSY), .SIG_B0(SIGS[0]), .SIG_B1(SIGS[1]),
		.SIG_B2(SIGS[2]), .CALIB(CAL)) nvm_device_port_i (
		.clk(clk), .rst(rst), .ce(1'b1), .pins(bus));
	nvm_port_props nvm_port_props_i (
		.clk(clk), .rst(rst), .actionSelectHi(bus.actionSelectHi),
		.actionSelectLo(bus.actionSelectLo),
		.loadPulseInput(bus.loadPulseInput),
		.pageLatchStrobe(bus.pageLatchStrobe),
		.writeStrobeN(bus.writeStrobeN), .outputEnableN(bus.outputEnableN),
		.readyBusyOut(bus.readyBusyOut), .hostData(bus.hostData),
		.hostDataOe(bus.hostDataOe), .devDataOe(bus.devDataOe));

	// clock and a hang guard sized well above the expected run
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 12000) begin
			failCount++;
			printVerdict();
		end
	end

	task automatic printVerdict();
		$display("checks=%0d mismatches=%0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// answers are compared mid-cycle, where the registered pulse is settled
	always @(negedge clk) begin
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0) begin
				check(rspData, 8'hXX);
			end else begin
				check(rspData, expQ.pop_front());
			end
		end
	end

	// hold the request until the edge that takes it, then drop it
	task automatic req(input nvm_port_pkg::req_kind_t k, input logic [7:0] b,
			input logic s1, input logic s2);
		int n = 0;
		@(posedge clk);
		reqValid <= 1'b1;
		reqKind <= k;
		reqByte <= b;
		reqBs1 <= s1;
		reqBs2 <= s2;
		@(negedge clk);
		while (reqReady !== 1'b1 && n < 2000) begin
			n++;
			@(negedge clk);
		end
		@(posedge clk);
		reqValid <= 1'b0;
	endtask

	task automatic cmd(input logic [7:0] b);
		req(nvm_port_pkg::REQ_CMD, b, 1'b0, 1'b0);
	endtask
	task automatic adr(input logic [7:0] b, input logic hi);
		req(nvm_port_pkg::REQ_ADDR, b, hi, 1'b0);
	endtask
	task automatic dat(input logic [7:0] b, input logic hi);
		req(nvm_port_pkg::REQ_DATA, b, hi, 1'b0);
	endtask
	task automatic wr(input logic s1, input logic s2);
		req(nvm_port_pkg::REQ_WRITE, 8'h00, s1, s2);
	endtask
	task automatic rd(input logic s1, input logic s2, input logic [7:0] x);
		expQ.push_back(x);
		req(nvm_port_pkg::REQ_READ, 8'h00, s1, s2);
	endtask
	task automatic drain();
		int n = 0;
		while (expQ.size() != 0 && n < 200) begin
			n++;
			@(posedge clk);
		end
	endtask

	// main sequence: erase, flash, eeprom, fuses, lock, identity bytes
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		cmd(nvm_port_pkg::CMD_ERASE);
		wr(1'b0, 1'b0);
		// page 0x45, first and last word positions
		cmd(nvm_port_pkg::CMD_WR_FLASH);
		for (i = 0; i < 2; i++) begin
			w[i] = 16'($random(seed));
			adr(i ? 8'hBF : 8'hA0, 1'b0);
			dat(w[i][7:0], 1'b0);
			dat(w[i][15:8], 1'b1);
			req(nvm_port_pkg::REQ_LATCH, 8'h00, 1'b1, 1'b0);
		end
		adr(8'h08, 1'b1);
		wr(1'b0, 1'b0);
		// a word latched before the no-op must never reach the array
		adr(8'hA1, 1'b0);
		dat(8'h00, 1'b0);
		dat(8'h00, 1'b1);
		req(nvm_port_pkg::REQ_LATCH, 8'h00, 1'b1, 1'b0);
		cmd(nvm_port_pkg::CMD_NOOP);
		cmd(nvm_port_pkg::CMD_WR_FLASH);
		wr(1'b0, 1'b0);
		cmd(nvm_port_pkg::CMD_RD_FLASH);
		adr(8'h08, 1'b1);
		for (i = 0; i < 2; i++) begin
			adr(i ? 8'hBF : 8'hA0, 1'b0);
			rd(1'b0, 1'b0, w[i][7:0]);
			rd(1'b1, 1'b0, w[i][15:8]);
		end
		adr(8'hA1, 1'b0);
		rd(1'b0, 1'b0, 8'hFF);
		rd(1'b1, 1'b0, 8'hFF);
		// eeprom page 0xB, bytes 1 and 2 only
		cmd(nvm_port_pkg::CMD_WR_EE);
		adr(8'h00, 1'b1);
		for (i = 0; i < 2; i++) begin
			e[i] = 8'($random(seed));
			adr(8'h2D + 8'(i), 1'b0);
			dat(e[i], 1'b0);
			req(nvm_port_pkg::REQ_LATCH, 8'h00, 1'b1, 1'b0);
		end
		wr(1'b0, 1'b0);
		cmd(nvm_port_pkg::CMD_RD_EE);
		for (i = 0; i < 2; i++) begin
			adr(8'h2D + 8'(i), 1'b0);
			rd(1'b0, 1'b0, e[i]);
		end
		adr(8'h2C, 1'b0);
		rd(1'b0, 1'b0, 8'hFF);
		// low, high and extended fuse bytes
		cmd(nvm_port_pkg::CMD_WR_FUSE);
		for (i = 0; i < 3; i++) begin
			f[i] = 8'($random(seed));
			dat(f[i], 1'b0);
			wr(i == 1, i == 2);
		end
		cmd(nvm_port_pkg::CMD_RD_FUSE);
		rd(1'b0, 1'b0, f[0]);
		rd(1'b1, 1'b1, f[1]);
		rd(1'b0, 1'b1, f[2]);
		// lock bits program down to mode 3, then further writes are refused
		for (i = 0; i < 3; i++) begin
			cmd(nvm_port_pkg::CMD_WR_LOCK);
			dat(LK_IN[i], 1'b0);
			wr(1'b0, 1'b0);
			cmd(nvm_port_pkg::CMD_RD_FUSE);
			rd(1'b1, 1'b0, LK_EXP[i]);
		end
		cmd(nvm_port_pkg::CMD_ERASE);
		wr(1'b0, 1'b0);
		cmd(nvm_port_pkg::CMD_RD_FUSE);
		rd(1'b1, 1'b0, 8'hFF);
		rd(1'b0, 1'b0, f[0]);
		// identity bytes, one blank address, then the calibration byte
		cmd(nvm_port_pkg::CMD_RD_SIG);
		for (i = 0; i < 4; i++) begin
			adr(8'(i), 1'b0);
			rd(1'b0, 1'b0, SIGS[i]);
		end
		adr(8'h00, 1'b0);
		rd(1'b1, 1'b0, CAL);
		// reset mid-run returns the fuses to their erased value
		drain();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		cmd(nvm_port_pkg::CMD_RD_FUSE);
		rd(1'b0, 1'b0, 8'hFF);
		drain();
		check(8'(devReady), 8'h01);
		if (expQ.size() != 0) begin
			failCount++;
		end
		printVerdict();
	end
endmodule // parallel_nvm_program_port_tb
